// *** mpic_top.sv ***
// Multiprocessor interrupt controller with four internal controllers
//
// Contract
// R01: Four internal controllers, each register copy on its own 4 KiB boundary.
// R02: Read-only controller-count field reads three: four register sets.
// R03: After reset every processor is routed to controller zero.
// R04: Select registers route processors; lock bit freezes them once written 1.
// R05: Software uses only its controller copy at n times 0x1000.
// R06: Per-processor registers readable everywhere, writable only via assigned controller.
// R07: Force clear only via assigned; set from any when force-from-any flag.
// R08: Lines 1-15 set sticky pending bits until cleared or acknowledged.
// R09: Level register puts each interrupt on level 0 or 1.
// R10: Level 1 first, line 15 highest within a level.
// R11: Prioritise shared, mask and forward per processor with own registers.
// R12: Acknowledge clears pending bit; first acknowledge from any processor wins.
// R13: Acknowledge of a forced interrupt clears the force bit instead.
// R14: Mask registers reset to zero.
// R15: Lines 16-31 also latched and masked, registers 32 bits wide.
// R16: Extended interrupts appear as line 10; acknowledge clears both bits.
// R17: Extended acknowledge register records last acknowledged extended number.
// R18: Status bit one means halted; writing one restarts a halted processor.
// R19: After reset all processors halted except processor 0.
// R20: Broadcast lines set every processor force bit instead of pending.
// R21: Driver reads control and select registers before using a controller.
// R22: Four-bit request level out; acknowledge strobe returns acknowledged level.
`timescale 1ns/1ps
module mpic_top (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [13:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // Interrupt bus
  input  wire logic [31:0] bus_interrupt_line,
  // Processor side, four-bit levels and one-bit strobes per processor
  output logic [15:0]      cpu_irq_level,
  input  wire logic [3:0]  cpu_ack,
  input  wire logic [15:0] cpu_ack_level,
  input  wire logic [3:0]  cpu_halted,
  output logic [3:0]       cpu_run,
  output logic [3:0]       cpu_restart
);

  localparam int NCPU = mpic_pkg::NCPU;
  localparam int NCTL = mpic_pkg::NCTL;

  // Highest set bit of a word, zero when none
  function automatic logic [4:0] top_idx(input logic [31:0] v);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 1; i < 32; i++) begin
      if (v[i]) begin
        r = 5'(i);
      end
    end
    return r;
  endfunction

  // Offset of a per-processor register
  function automatic logic [11:0] cpu_ofs(input logic [11:0] base, input int k);
    return base + 12'(k * 4);
  endfunction

  // State
  logic        pready_q;
  logic [31:0] prdata_q;
  logic        pslverr_q;
  logic [31:0] level_q [NCTL];
  logic [31:0] pend_q  [NCTL];
  logic [31:0] pend_d  [NCTL];
  logic [31:0] bcast_q [NCTL];
  logic [31:0] mask_q  [NCPU];
  logic [15:0] force_q [NCPU];
  logic [15:0] force_d [NCPU];
  logic [4:0]  eack_q  [NCPU];
  logic [1:0]  sel_q   [NCPU];
  logic        lock_q;
  logic        force_set_from_any_flag_q;
  logic [3:0]  halt_q;
  logic [3:0]  halt_d;
  logic [3:0]  start_d;
  logic [15:0] irq_q;
  logic [15:0] irq_d;
  logic [3:0]  restart_q;
  logic [3:0]  run_q;

  // Per-processor acknowledge decode
  logic [3:0]  ack_lvl [NCPU];
  logic        ack_frc [NCPU];
  logic        ack_ext [NCPU];
  logic [4:0]  ext_idx [NCPU];

  // Bus decode
  logic        xfer;
  logic        wr;
  logic [1:0]  ctl;
  logic [11:0] ofs;
  logic [31:0] rd_d;
  logic        err_d;

  // A write lands only at the edge where the master sees pready
  assign xfer = psel & penable & pready_q;
  assign wr   = xfer & pwrite;
  assign ctl  = paddr[13:mpic_pkg::CTL_LSB];  // R01
  assign ofs  = paddr[11:0];

  // APB answer one cycle into the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= psel & penable & ~pready_q;
      if (psel & penable & ~pready_q) begin
        prdata_q  <= pwrite ? 32'h0000_0000 : rd_d;
        pslverr_q <= err_d;
      end else begin
        pslverr_q <= 1'b0;
      end
    end
  end

  // Read mux and unmapped detection
  always_comb begin
    rd_d  = 32'h0000_0000;
    err_d = 1'b0;
    unique case (ofs)
      mpic_pkg::OFS_LEVEL:  rd_d = level_q[ctl];
      mpic_pkg::OFS_PEND:   rd_d = pend_q[ctl];
      mpic_pkg::OFS_CLEAR:  rd_d = 32'h0000_0000;
      mpic_pkg::OFS_BCAST:  rd_d = bcast_q[ctl];
      mpic_pkg::OFS_STATUS: begin
        rd_d[mpic_pkg::ST_NCPU_LSB +: 4] = mpic_pkg::NCPU_VAL;
        rd_d[mpic_pkg::ST_EIRQ_LSB +: 4] = mpic_pkg::EXT_IRQ;
        rd_d[3:0] = halt_q;  // R18
      end
      mpic_pkg::OFS_AMP: begin
        rd_d[mpic_pkg::AMP_COUNT_LSB +: 4] = mpic_pkg::CTL_COUNT_VAL;  // R02
        rd_d[mpic_pkg::AMP_ANYSET_BIT] = force_set_from_any_flag_q;
        rd_d[mpic_pkg::AMP_LOCK_BIT] = lock_q;
      end
      mpic_pkg::OFS_SEL: begin
        for (int k = 0; k < NCPU; k++) begin
          rd_d[k*mpic_pkg::SEL_FIELD_W +: 2] = sel_q[k];
        end
      end
      default: begin
        err_d = 1'b1;
        // Per-processor registers readable from every copy
        for (int k = 0; k < NCPU; k++) begin
          if (ofs == cpu_ofs(mpic_pkg::OFS_MASK, k)) begin
            rd_d  = mask_q[k];  // R06
            err_d = 1'b0;
          end
          if (ofs == cpu_ofs(mpic_pkg::OFS_FORCE, k)) begin
            rd_d  = {16'h0000, force_q[k]};
            err_d = 1'b0;
          end
          if (ofs == cpu_ofs(mpic_pkg::OFS_EACK, k)) begin
            rd_d  = {27'h0000000, eack_q[k]};
            err_d = 1'b0;
          end
        end
      end
    endcase
  end

  // Acknowledge decode: forced, extended or plain
  always_comb begin
    for (int k = 0; k < NCPU; k++) begin
      ack_lvl[k] = cpu_ack_level[k*4 +: 4];  // R22
      ack_frc[k] = cpu_ack[k] & force_q[k][ack_lvl[k]];  // R13
      ext_idx[k] = top_idx({pend_q[sel_q[k]][31:16] & mask_q[k][31:16], 16'h0000});
      ack_ext[k] = cpu_ack[k] & ~ack_frc[k] & (ack_lvl[k] == mpic_pkg::EXT_IRQ)
                   & (ext_idx[k] != 5'h00);  // R16
    end
  end

  // Pending update per controller, set wins over clear
  always_comb begin
    for (int c = 0; c < NCTL; c++) begin
      pend_d[c] = pend_q[c];
      if (wr && ctl == 2'(c) && ofs == mpic_pkg::OFS_PEND) begin
        pend_d[c] = pwdata & mpic_pkg::LINE_MASK;
      end
      if (wr && ctl == 2'(c) && ofs == mpic_pkg::OFS_CLEAR) begin
        pend_d[c] = pend_d[c] & ~pwdata;
      end
      for (int k = 0; k < NCPU; k++) begin
        if (cpu_ack[k] && !ack_frc[k] && sel_q[k] == 2'(c)) begin
          pend_d[c][ack_lvl[k]] = 1'b0;  // R12
          if (ack_ext[k]) begin
            pend_d[c][ext_idx[k]] = 1'b0;  // R16
          end
        end
      end
      // New bus events go in last so they beat a clear or ack
      // R08 R15 R20
      pend_d[c] = pend_d[c] | (bus_interrupt_line & ~bcast_q[c] & mpic_pkg::LINE_MASK);
    end
  end

  // Force update per processor
  always_comb begin
    for (int k = 0; k < NCPU; k++) begin
      force_d[k] = force_q[k];
      if (wr && ofs == cpu_ofs(mpic_pkg::OFS_FORCE, k)) begin
        if (sel_q[k] == ctl) begin
          force_d[k] = force_d[k] & ~pwdata[mpic_pkg::FORCE_CLR_LSB +: 16];  // R07
        end
        if (sel_q[k] == ctl || force_set_from_any_flag_q) begin
          force_d[k] = force_d[k] | pwdata[15:0];  // R07
        end
      end
      // Forced bit takes the acknowledge, pending bit left alone
      if (ack_frc[k]) begin
        force_d[k][ack_lvl[k]] = 1'b0;  // R13
      end
      // R20
      force_d[k] = force_d[k] | (bus_interrupt_line[15:0] & bcast_q[sel_q[k]][15:0]);
      force_d[k][0] = 1'b0;
    end
  end

  // Request level per processor
  always_comb begin
    logic [31:0] pl;
    logic [15:0] req;
    logic [15:0] hi;
    logic [4:0]  hi_idx;
    logic [4:0]  req_idx;
    pl  = 32'h0000_0000;
    req = 16'h0000;
    hi  = 16'h0000;
    hi_idx  = 5'h00;
    req_idx = 5'h00;
    irq_d = 16'h0000;
    for (int k = 0; k < NCPU; k++) begin
      // R11
      pl  = (pend_q[sel_q[k]] | {16'h0000, force_q[k]}) & mask_q[k];
      req = pl[15:0];
      if (|pl[31:16]) begin
        req[mpic_pkg::EXT_IRQ] = 1'b1;  // R16
      end
      req[0] = 1'b0;
      hi  = req & level_q[sel_q[k]][15:0];  // R09
      hi_idx  = top_idx({16'h0000, hi});
      req_idx = top_idx({16'h0000, req});
      // Indices stay below 16, so the top bit is dropped on purpose
      irq_d[k*4 +: 4] = (|hi) ? hi_idx[3:0] : req_idx[3:0];  // R10
    end
  end

  // Halt and restart
  always_comb begin
    start_d = 4'h0;
    for (int k = 0; k < NCPU; k++) begin
      start_d[k] = wr && ofs == mpic_pkg::OFS_STATUS && sel_q[k] == ctl
                   && pwdata[k] && halt_q[k];  // R06 R18
    end
    // A halt report beats a restart write in the same cycle
    halt_d = (halt_q & ~start_d) | cpu_halted;
  end

  // Controller-copy registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int c = 0; c < NCTL; c++) begin
        level_q[c] <= 32'h0000_0000;
        pend_q[c]  <= 32'h0000_0000;
        bcast_q[c] <= 32'h0000_0000;
      end
    end else begin
      for (int c = 0; c < NCTL; c++) begin
        pend_q[c] <= pend_d[c];
        if (wr && ctl == 2'(c) && ofs == mpic_pkg::OFS_LEVEL) begin
          level_q[c] <= pwdata & mpic_pkg::LINE_MASK;  // R09
        end
        if (wr && ctl == 2'(c) && ofs == mpic_pkg::OFS_BCAST) begin
          bcast_q[c] <= pwdata & mpic_pkg::LINE_MASK;
        end
      end
    end
  end

  // Per-processor mask, force and extended acknowledge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int k = 0; k < NCPU; k++) begin
        mask_q[k]  <= mpic_pkg::MASK_RST;  // R14
        force_q[k] <= 16'h0000;
        eack_q[k]  <= 5'h00;
      end
    end else begin
      for (int k = 0; k < NCPU; k++) begin
        force_q[k] <= force_d[k];
        if (wr && ofs == cpu_ofs(mpic_pkg::OFS_MASK, k) && sel_q[k] == ctl) begin
          mask_q[k] <= pwdata & mpic_pkg::LINE_MASK;  // R06 R15
        end
        if (ack_ext[k]) begin
          eack_q[k] <= ext_idx[k];  // R17
        end
      end
    end
  end

  // Routing, lock and force-from-any flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int k = 0; k < NCPU; k++) begin
        sel_q[k] <= 2'h0;  // R03
      end
      lock_q <= 1'b0;
      force_set_from_any_flag_q <= 1'b0;
    end else begin
      // Lock is sticky until reset; select writes drop after it
      if (wr && ofs == mpic_pkg::OFS_SEL && !lock_q) begin
        for (int k = 0; k < NCPU; k++) begin
          sel_q[k] <= pwdata[k*mpic_pkg::SEL_FIELD_W +: 2];  // R04
        end
      end
      if (wr && ofs == mpic_pkg::OFS_AMP) begin
        lock_q <= lock_q | pwdata[mpic_pkg::AMP_LOCK_BIT];  // R04
        force_set_from_any_flag_q <= pwdata[mpic_pkg::AMP_ANYSET_BIT];  // R07
      end
    end
  end

  // Halt status and run outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      halt_q <= mpic_pkg::HALT_RST;  // R19
      run_q  <= ~mpic_pkg::HALT_RST;  // R19
    end else begin
      halt_q <= halt_d;
      run_q  <= ~halt_d;  // R18
    end
  end

  // Request level outputs, one cycle behind the state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q <= 16'h0000;
    end else begin
      irq_q <= irq_d;  // R22
    end
  end

  // Restart pulse, dropped when a halt report arrives at once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      restart_q <= 4'h0;
    end else begin
      restart_q <= start_d & ~cpu_halted;  // R18
    end
  end

  assign pready        = pready_q;
  assign prdata        = prdata_q;
  assign pslverr       = pslverr_q;
  assign cpu_irq_level = irq_q;
  assign cpu_restart   = restart_q;
  assign cpu_run       = run_q;

endmodule

// *** mpic_pkg.sv ***
// Constants for the multiprocessor interrupt controller
package mpic_pkg;
  // Sizes
  localparam int NCPU = 4;
  localparam int NCTL = 4;
  localparam logic [3:0] CTL_COUNT_VAL = 4'h3;  // Register sets minus one
  localparam logic [3:0] NCPU_VAL  = 4'h3;  // Processors minus one
  localparam logic [3:0] EXT_IRQ   = 4'hA;  // Regular line for extended
  // Address split: controller index above 4 KiB boundary
  localparam int CTL_LSB = 12;
  // Register offsets within one copy
  localparam logic [11:0] OFS_LEVEL  = 12'h000;
  localparam logic [11:0] OFS_PEND   = 12'h004;
  localparam logic [11:0] OFS_CLEAR  = 12'h00C;
  localparam logic [11:0] OFS_STATUS = 12'h010;
  localparam logic [11:0] OFS_BCAST  = 12'h014;
  localparam logic [11:0] OFS_AMP    = 12'h020;
  localparam logic [11:0] OFS_SEL    = 12'h024;
  localparam logic [11:0] OFS_MASK   = 12'h040;
  localparam logic [11:0] OFS_FORCE  = 12'h080;
  localparam logic [11:0] OFS_EACK   = 12'h0C0;
  // Field positions
  localparam int AMP_LOCK_BIT  = 0;
  localparam int AMP_ANYSET_BIT = 1;
  localparam int AMP_COUNT_LSB  = 28;
  localparam int ST_NCPU_LSB   = 28;
  localparam int ST_EIRQ_LSB   = 16;
  localparam int FORCE_CLR_LSB = 16;
  localparam int SEL_FIELD_W   = 4;
  // Valid interrupt lines, line 0 unused
  localparam logic [31:0] LINE_MASK = 32'hFFFF_FFFE;
  // Reset values
  localparam logic [31:0] MASK_RST = 32'h0000_0000;
  localparam logic [3:0]  HALT_RST = 4'hE;  // Only processor 0 runs
endpackage

// *** mpic_top_props.sv ***
// Port checker for the interrupt controller
`timescale 1ns/1ps
module mpic_top_props (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB side
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [13:0] paddr,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  // Processor side
  input wire logic [3:0]  cpu_halted,
  input wire logic [3:0]  cpu_run,
  input wire logic [3:0]  cpu_restart
);
  logic rd_ok;
  // Completed read
  assign rd_ok = psel && penable && pready && !pwrite;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_timing: assert property (psel && !penable |-> ##2 pready)
    else $error("ready late");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_err_hole: assert property (rd_ok && paddr[11:0] == 12'h008 |-> pslverr)
    else $error("hole not refused");
  a_write_zero: assert property (pready && pwrite |-> prdata == 32'h0)
    else $error("write data nonzero");
  a_count_field: assert property (rd_ok && paddr[11:0] == 12'h020 |-> prdata[31:28] == 4'h3)
    else $error("count field wrong");
  a_halt_stops: assert property (|cpu_halted |=> (cpu_run & $past(cpu_halted)) == 4'h0)
    else $error("halted cpu runs");
  a_restart_runs: assert property (|cpu_restart |-> (cpu_restart & ~cpu_run) == 4'h0)
    else $error("restart without run");
  a_restart_cause: assert property (|cpu_restart |-> $past(psel && pready && pwrite))
    else $error("restart without write");
endmodule
bind mpic_top mpic_top_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready), .prdata(prdata),
  .pslverr(pslverr), .cpu_halted(cpu_halted), .cpu_run(cpu_run),
  .cpu_restart(cpu_restart));

// *** mpic_cpu_model.sv ***
// Processor cores that acknowledge forwarded levels
`timescale 1ns/1ps
module mpic_cpu_model (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // Controller side
  input wire logic [15:0] cpu_irq_level,
  input wire logic [3:0]  ack_en,
  output logic [3:0]      cpu_ack,
  output logic [15:0]     cpu_ack_level
);
  logic [2:0] hold_q [4];
  // One acknowledge per grant, then a hold-off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_ack <= 4'h0;
      cpu_ack_level <= 16'h0;
      for (int k = 0; k < 4; k++) hold_q[k] <= 3'h0;
    end else begin
      for (int k = 0; k < 4; k++) begin
        if (hold_q[k] != 3'h0) begin
          hold_q[k] <= hold_q[k] - 3'h1;
          cpu_ack[k] <= 1'b0;
          cpu_ack_level[4*k+:4] <= ~cpu_ack_level[4*k+:4];  // Not valid outside ack
        end else if (ack_en[k] && cpu_irq_level[4*k+:4] != 4'h0) begin
          cpu_ack[k] <= 1'b1;
          cpu_ack_level[4*k+:4] <= cpu_irq_level[4*k+:4];
          hold_q[k] <= 3'h4;
        end else begin
          cpu_ack[k] <= 1'b0;
          cpu_ack_level[4*k+:4] <= ~cpu_ack_level[4*k+:4];  // Not valid outside ack
        end
      end
    end
  end
endmodule

// *** mpic_top_tb_top.sv ***
// Testbench for the multiprocessor interrupt controller
`timescale 1ns/1ps
module mpic_top_tb_top;
  logic        pclk;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic        pready, pslverr, er;
  logic [13:0] paddr = 14'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] lines = 32'h0;
  logic [31:0] prdata, rd;
  logic [15:0] irq, ack_lvl;
  logic [3:0]  ack, run, rst;
  logic [3:0]  halt = 4'h0;
  logic [3:0]  ack_en = 4'h0;
  int          n_errors = 0;
  int          num_checks = 0;
  int          cyc = 0;
  mpic_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .bus_interrupt_line(lines), .cpu_irq_level(irq), .cpu_ack(ack),
    .cpu_ack_level(ack_lvl), .cpu_halted(halt), .cpu_run(run), .cpu_restart(rst));
  mpic_cpu_model cpus (.pclk(pclk), .presetn(presetn), .cpu_irq_level(irq),
    .ack_en(ack_en), .cpu_ack(ack), .cpu_ack_level(ack_lvl));
  // Clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // Hang guard
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      end_sim();
    end
  end
  task end_sim;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task wt(input int c);
    repeat (c) @(posedge pclk);
  endtask
  task apb(input logic w, input logic [13:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Wait for pready; only the hang guard ends this wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [13:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rc(input logic [13:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task pulse(input logic [31:0] m);
    @(posedge pclk);
    lines <= m;
    @(posedge pclk);
    lines <= 32'h0;
    wt(3);
  endtask
  task ack0;
    @(posedge pclk);
    ack_en <= 4'h1;
    @(posedge pclk);
    ack_en <= 4'h0;
    wt(4);
  endtask
  task lv0(input logic [3:0] e);
    chk({28'h0, irq[3:0]}, {28'h0, e});
  endtask
  // Reset values
  task t_reset;
    rc(14'h010, 32'h300A000E);
    rc(14'h020, 32'h30000000);
    rc(14'h024, 32'h0);
    rc(14'h040, 32'h0);
    chk({28'h0, run}, 32'h1);
    $display("reset test done");
  endtask
  // Priority, sticky pending, acknowledge
  task t_prio;
    wr(14'h040, 32'hFFFFFFFE);
    wr(14'h000, 32'h8);
    pulse(32'h8028);
    rc(14'h004, 32'h8028);
    lv0(4'h3);
    chk({28'h0, irq[7:4]}, 32'h0);
    wr(14'h00C, 32'h8);
    wt(3);
    lv0(4'hF);
    ack0();
    rc(14'h004, 32'h20);
    lv0(4'h5);
    ack0();
    rc(14'h004, 32'h0);
    $display("priority test done");
  endtask
  // Extended line through line 10
  task t_ext;
    pulse(32'h00100000);
    lv0(4'hA);
    ack0();
    rc(14'h0C0, 32'h14);
    rc(14'h004, 32'h0);
    $display("extended test done");
  endtask
  // Controller routing and write rights
  task t_asmp;
    wr(14'h024, 32'h20);
    rc(14'h024, 32'h20);
    wr(14'h044, 32'hFFFF);
    rc(14'h044, 32'h0);
    wr(14'h2044, 32'h8);
    rc(14'h044, 32'h8);
    wr(14'h084, 32'h2);
    rc(14'h084, 32'h0);
    wr(14'h020, 32'h2);
    wr(14'h084, 32'h2);
    rc(14'h2084, 32'h2);
    wr(14'h084, 32'h20000);
    rc(14'h084, 32'h2);
    wr(14'h2084, 32'h20000);
    rc(14'h084, 32'h0);
    wr(14'h020, 32'h3);
    wr(14'h024, 32'h0);
    rc(14'h024, 32'h20);
    wr(14'h3000, 32'h10);
    rc(14'h0000, 32'h8);
    rc(14'h008, 32'h0);
    chk({31'h0, er}, 32'h1);
    $display("routing test done");
  endtask
  // Forced interrupt acknowledge
  task t_force;
    pulse(32'h10);
    wr(14'h080, 32'h10);
    wt(3);
    lv0(4'h4);
    ack0();
    rc(14'h080, 32'h0);
    rc(14'h004, 32'h10);
    ack0();
    rc(14'h004, 32'h0);
    $display("force test done");
  endtask
  // Broadcast into force registers
  task t_bcast;
    wr(14'h014, 32'h40);
    pulse(32'h40);
    rc(14'h004, 32'h0);
    rc(14'h080, 32'h40);
    rc(14'h088, 32'h40);
    ack0();
    rc(14'h080, 32'h0);
    $display("broadcast test done");
  endtask
  // Halt and restart
  task t_restart;
    wr(14'h010, 32'h2);
    wt(1);
    chk({31'h0, run[1]}, 32'h0);
    chk({28'h0, rst}, 32'h0);
    wr(14'h010, 32'h4);
    wt(1);
    chk({28'h0, run}, 32'h5);
    chk({28'h0, rst}, 32'h4);
    rc(14'h010, 32'h300A000A);
    @(posedge pclk);
    halt <= 4'h4;
    @(posedge pclk);
    halt <= 4'h0;
    rc(14'h010, 32'h300A000E);
    $display("restart test done");
  endtask
  // Main sequence
  initial begin
    wt(10);
    presetn <= 1'b1;
    t_reset();
    t_prio();
    t_ext();
    t_asmp();
    t_force();
    t_bcast();
    t_restart();
    end_sim();
  end
endmodule
